// ### ntac_defs.vh
`ifndef NTAC_DEFS_VH
`define NTAC_DEFS_VH

// register byte offsets (haddr[7:0])
`define NTAC_OFS_CTRL 8'h00
`define NTAC_OFS_UNLOCK 8'h04
`define NTAC_OFS_LATCH 8'h08
`define NTAC_OFS_PTR_LOW 8'h0c
`define NTAC_OFS_PTR_HIGH 8'h10
`define NTAC_OFS_PTR_UPPER 8'h14
`define NTAC_OFS_TBL_OP 8'h18
`define NTAC_OFS_IRQ_STAT 8'h1c
`define NTAC_OFS_IRQ_CLR 8'h20
`define NTAC_OFS_IRQ_EN 8'h24

// control register fields
`define NTAC_CTRL_REGION_LO 0
`define NTAC_CTRL_REGION_HI 1
`define NTAC_CTRL_ERASE 2
`define NTAC_CTRL_ALLOW 3
`define NTAC_CTRL_START 4
`define NTAC_CTRL_FAULT 5

// region_select encodings
`define NTAC_REGION_EEPROM 2'b00
`define NTAC_REGION_FLASH 2'b10
`define NTAC_REGION_ID_BIT 0

// table operation register fields
`define NTAC_OP_READ 0
`define NTAC_OP_WRITE 1
`define NTAC_OP_MODE_LO 2
`define NTAC_OP_MODE_HI 3

// pointer update modes
`define NTAC_PTR_KEEP 2'b00
`define NTAC_PTR_POST_INC 2'b01
`define NTAC_PTR_POST_DEC 2'b10
`define NTAC_PTR_PRE_INC 2'b11

// pointer layout
`define NTAC_PTR_W 22
`define NTAC_PTR_LOW_W 21
`define NTAC_PTR_ID_BIT 21

// interrupt status bits
`define NTAC_IRQ_DONE 0
`define NTAC_IRQ_ABORT 1
`define NTAC_IRQ_W 2

// unlock sequence keys
`define NTAC_KEY_FIRST 8'h55
`define NTAC_KEY_SECOND 8'haa
`define NTAC_UNL_IDLE 2'b00
`define NTAC_UNL_HALF 2'b01
`define NTAC_UNL_ARMED 2'b10

// erased flash byte
`define NTAC_ERASED 8'hff

`endif

// ### ntac_nvm_ctrl.v
`include "ntac_defs.vh"

// Contract
// - Reading the unlock port always returns zero; it holds no data.
// - region_select 00 targets EEPROM, 10 flash, x1 the ID space.
// - With erase_select set a flash write_start erases instead of writes.
// - Program or erase runs only while allowed; allow clears at reset.
// - write_fault_flag sets on write_start, clears on good completion.
// - write_start starts an EEPROM erase-write, an ID byte write or a flash block write.
// - Software can only set write_start; hardware clears it at the end.
// - nvm_done_flag sets at write completion and stays until cleared.
// - table_latch is an 8-bit register visible to software.
// - The pointer is upper:high:low forming 22 bits; bit 21 selects ID.
// - Table operations update the pointer four ways, low 21 bits only.
// - A table read uses pointer bit 21 and the low address bits and loads the latch.
// - A table write puts the latch byte into the holding block slot.
// - A flash write copies the holding block to the pointer's block.
module ntac_nvm_ctrl #(
	parameter HOLD_BITS = 5,
	parameter PFM_AW = 10,
	parameter ID_AW = 4,
	parameter EE_AW = 8,
	parameter [15:0] WRITE_CYCLES = 16'd100
) (
	input wire ref_clk,
	input wire arst_n,
	input wire ce,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,
	output reg irq
);

localparam HOLD_N = 1 << HOLD_BITS;

reg pend;
reg pend_wr;
reg [7:0] pend_addr;
reg [1:0] region_select;
reg erase_select;
reg program_erase_allow;
reg write_start;
reg write_fault_flag;
reg [1:0] unlock_st;
reg [7:0] table_latch;
reg [21:0] table_pointer;
reg [1:0] irq_stat;
reg [1:0] irq_en;
reg [15:0] tmr;

reg [7:0] program_flash [0:(1<<PFM_AW)-1];
reg [7:0] idm [0:(1<<ID_AW)-1];
reg [7:0] eem [0:(1<<EE_AW)-1];
reg [7:0] hold [0:HOLD_N-1];

integer i;

function [21:0] ptr_step;
	input [21:0] p;
	input [1:0] m;
	reg [20:0] lo;
	begin
		lo = p[`NTAC_PTR_LOW_W-1:0];
		case (m)
			`NTAC_PTR_POST_INC, `NTAC_PTR_PRE_INC: lo = lo + 21'h1;
			`NTAC_PTR_POST_DEC: lo = lo - 21'h1;
			default: lo = lo;
		endcase
		ptr_step = {p[`NTAC_PTR_ID_BIT], lo};
	end
endfunction

wire take = ce & hsel & htrans[1] & hready;
wire wr_now = ce & pend & pend_wr;
wire [7:0] wbyte = hwdata[7:0];
wire op_acc = wr_now & (pend_addr == `NTAC_OFS_TBL_OP);
wire [1:0] op_mode = hwdata[`NTAC_OP_MODE_HI:`NTAC_OP_MODE_LO];
wire op_rd = op_acc & hwdata[`NTAC_OP_READ];
wire op_wr = op_acc & hwdata[`NTAC_OP_WRITE];
wire [21:0] stepped = ptr_step(table_pointer, op_mode);
wire [21:0] acc_ptr = (op_mode == `NTAC_PTR_PRE_INC) ? stepped
	: table_pointer;
wire start_req = wr_now & (pend_addr == `NTAC_OFS_CTRL)
	& hwdata[`NTAC_CTRL_START];
wire allow_next = (wr_now & (pend_addr == `NTAC_OFS_CTRL))
	? hwdata[`NTAC_CTRL_ALLOW] : program_erase_allow;
// start only when allowed and unlocked
wire start_ok = start_req & allow_next & ~write_start
	& (unlock_st == `NTAC_UNL_ARMED);
wire run = ce & write_start;
// dropping allow aborts a running cycle
wire abort_evt = run & ~program_erase_allow;
wire done_evt = run & program_erase_allow & (tmr == 16'h1);
wire [PFM_AW-HOLD_BITS-1:0] blk = table_pointer[PFM_AW-1:HOLD_BITS];

wire [1:0] set_bits;
assign set_bits[`NTAC_IRQ_DONE] = done_evt;
assign set_bits[`NTAC_IRQ_ABORT] = abort_evt;

reg [31:0] rd_mux;
always @* begin
	rd_mux = 32'h0;
	case (pend_addr)
		`NTAC_OFS_CTRL: begin
			rd_mux[`NTAC_CTRL_REGION_HI:`NTAC_CTRL_REGION_LO] = region_select;
			rd_mux[`NTAC_CTRL_ERASE] = erase_select;
			rd_mux[`NTAC_CTRL_ALLOW] = program_erase_allow;
			rd_mux[`NTAC_CTRL_START] = write_start;
			rd_mux[`NTAC_CTRL_FAULT] = write_fault_flag;
		end
		`NTAC_OFS_UNLOCK: rd_mux = 32'h0;
		`NTAC_OFS_LATCH: rd_mux[7:0] = table_latch;
		`NTAC_OFS_PTR_LOW: rd_mux[7:0] = table_pointer[7:0];
		`NTAC_OFS_PTR_HIGH: rd_mux[7:0] = table_pointer[15:8];
		`NTAC_OFS_PTR_UPPER: rd_mux[5:0] = table_pointer[21:16];
		`NTAC_OFS_IRQ_STAT: rd_mux[`NTAC_IRQ_W-1:0] = irq_stat;
		`NTAC_OFS_IRQ_EN: rd_mux[`NTAC_IRQ_W-1:0] = irq_en;
		default: rd_mux = 32'h0;
	endcase
end

always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		pend <= 1'b0;
		pend_wr <= 1'b0;
		pend_addr <= 8'h00;
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		hrdata <= 32'h0;
		irq <= 1'b0;
		region_select <= 2'b00;
		erase_select <= 1'b0;
		program_erase_allow <= 1'b0;
		write_start <= 1'b0;
		write_fault_flag <= 1'b0;
		unlock_st <= `NTAC_UNL_IDLE;
		table_latch <= 8'h00;
		table_pointer <= 22'h0;
		irq_stat <= 2'b00;
		irq_en <= 2'b00;
		tmr <= 16'h0;
	end else if (ce) begin
		// one wait state per transfer so hrdata comes from a flop
		if (take) begin
			pend <= 1'b1;
			pend_wr <= hwrite;
			pend_addr <= haddr[7:0];
			hreadyout <= 1'b0;
		end else if (pend) begin
			pend <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= pend_wr ? 32'h0 : rd_mux;
		end
		irq <= |(irq_stat & irq_en);
		if (wr_now) begin
			case (pend_addr)
				`NTAC_OFS_CTRL: begin
					region_select <= hwdata[`NTAC_CTRL_REGION_HI:`NTAC_CTRL_REGION_LO];
					erase_select <= hwdata[`NTAC_CTRL_ERASE];
					program_erase_allow <= hwdata[`NTAC_CTRL_ALLOW];
				end
				`NTAC_OFS_UNLOCK: begin
					if (wbyte == `NTAC_KEY_FIRST)
						unlock_st <= `NTAC_UNL_HALF;
					else if (wbyte == `NTAC_KEY_SECOND
						&& unlock_st == `NTAC_UNL_HALF)
						unlock_st <= `NTAC_UNL_ARMED;
					else
						unlock_st <= `NTAC_UNL_IDLE;
				end
				`NTAC_OFS_LATCH: table_latch <= wbyte;
				`NTAC_OFS_PTR_LOW: table_pointer[7:0] <= wbyte;
				`NTAC_OFS_PTR_HIGH: table_pointer[15:8] <= wbyte;
				`NTAC_OFS_PTR_UPPER: table_pointer[21:16] <= wbyte[5:0];
				`NTAC_OFS_IRQ_EN: irq_en <= hwdata[`NTAC_IRQ_W-1:0];
				default: ;
			endcase
		end
		if (op_rd | op_wr)
			table_pointer <= (op_mode == `NTAC_PTR_PRE_INC) ? stepped
				: ptr_step(table_pointer, op_mode);
		if (op_rd)
			table_latch <= acc_ptr[`NTAC_PTR_ID_BIT]
				? idm[acc_ptr[ID_AW-1:0]] : program_flash[acc_ptr[PFM_AW-1:0]];
		if (wr_now && pend_addr == `NTAC_OFS_IRQ_CLR)
			irq_stat <= (irq_stat & ~hwdata[`NTAC_IRQ_W-1:0]) | set_bits;
		else
			irq_stat <= irq_stat | set_bits;
		if (start_ok) begin
			write_start <= 1'b1;
			write_fault_flag <= 1'b1;
			tmr <= WRITE_CYCLES;
			unlock_st <= `NTAC_UNL_IDLE;
		end else if (abort_evt) begin
			write_start <= 1'b0;
		end else if (done_evt) begin
			write_start <= 1'b0;
			write_fault_flag <= 1'b0;
		end else if (run) begin
			tmr <= tmr - 16'h1;
		end
	end
end

// memories carry no reset
always @(posedge ref_clk) begin
	if (ce) begin
		if (op_wr)
			hold[acc_ptr[HOLD_BITS-1:0]] <= table_latch;
		if (done_evt) begin
			if (region_select[`NTAC_REGION_ID_BIT])
				idm[table_pointer[ID_AW-1:0]] <= table_latch;
			else if (region_select == `NTAC_REGION_EEPROM)
				eem[table_pointer[EE_AW-1:0]] <= table_latch;
			else if (region_select == `NTAC_REGION_FLASH) begin
				for (i = 0; i < HOLD_N; i = i + 1)
					// erase fills block with erased bytes
					program_flash[{blk, i[HOLD_BITS-1:0]}] <= erase_select
						? `NTAC_ERASED : hold[i];
			end
		end
	end
end

endmodule // ntac_nvm_ctrl

// ### ntac_nvm_ctrl_monitor.sv
module ntac_nvm_ctrl_monitor (
	input wire ref_clk,
	input wire arst_n,
	input wire ce,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	wire tk = ce & hsel & htrans[1] & hready;
	wire rd = tk & !hwrite;
	sequence s_ans;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_resp; !hresp; endproperty
	a_resp: assert property (p_resp) else $error("hresp not okay");
	property p_wait; tk |=> s_ans; endproperty
	a_wait: assert property (p_wait) else $error("wait state wrong");
	property p_unl; rd && haddr[7:0] == 8'h04 |-> ##2 hrdata == 32'h0;
	endproperty
	a_unl: assert property (p_unl) else $error("unlock read");
	property p_lat; rd && haddr[7:0] == 8'h08 |-> ##2 hrdata[31:8] == 24'h0;
	endproperty
	a_lat: assert property (p_lat) else $error("latch width");
	property p_upr; rd && haddr[7:0] == 8'h14 |-> ##2 hrdata[31:6] == 26'h0;
	endproperty
	a_upr: assert property (p_upr) else $error("upper width");
	property p_ctl; rd && haddr[7:0] == 8'h00 |-> ##2 hrdata[31:6] == 26'h0;
	endproperty
	a_ctl: assert property (p_ctl) else $error("ctrl width");
	property p_map; rd && haddr[7:0] > 8'h24 |-> ##2 hrdata == 32'h0;
	endproperty
	a_map: assert property (p_map) else $error("unmapped read");
	property p_wrz; tk && hwrite |-> ##2 hrdata == 32'h0; endproperty
	a_wrz: assert property (p_wrz) else $error("write data phase");
endmodule // ntac_nvm_ctrl_monitor

bind ntac_nvm_ctrl ntac_nvm_ctrl_monitor u_mon (.ref_clk(ref_clk),
	.arst_n(arst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata));

// ### ntac_cpu_model.sv
module ntac_cpu_model (
	input wire ref_clk,
	input wire hready,
	input wire [31:0] hrdata,
	output logic hsel = 1'b0,
	output logic [31:0] haddr = 32'h0,
	output logic [1:0] htrans = 2'h0,
	output logic hwrite = 1'b0,
	output logic [31:0] hwdata = 32'h0
);
	timeunit 1ns;
	timeprecision 100ps;
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge ref_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		// reads put a changing pattern on the idle data bus
		hwdata <= w ? d : ~hwdata;
		do @(posedge ref_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule // ntac_cpu_model

// ### ntac_nvm_ctrl_tb.sv
module ntac_nvm_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, irq;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, q;
	int err_total = 0;
	int comparisons = 0;
	initial forever #12.5 ref_clk = ~ref_clk;
	ntac_cpu_model u_ntac_cpu_model (.ref_clk(ref_clk), .hready(hreadyout),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hwdata(hwdata));
	ntac_nvm_ctrl #(.HOLD_BITS(3), .WRITE_CYCLES(16'd40)) u_ntac_nvm_ctrl (
		.ref_clk(ref_clk), .arst_n(arst_n), .ce(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .irq(irq));
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		u_ntac_cpu_model.xfer(1'b1, a, d, q);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		u_ntac_cpu_model.xfer(1'b0, a, 32'h0, q);
		chk($sformatf("reg %h", a), q, e);
	endtask
	// poll the start bit without writing the control register
	task wait_idle;
		for (int i = 0; i < 60; i++) begin
			u_ntac_cpu_model.xfer(1'b0, 8'h00, 32'h0, q);
			if (q[4] === 1'b0) break;
		end
		chk("start bit", {31'h0, q[4]}, 32'h0);
	endtask
	// unlock, start, then wait for the start bit to drop
	task go(input logic [31:0] c);
		wr(8'h04, 32'h55);
		wr(8'h04, 32'haa);
		wr(8'h00, c);
		wait_idle;
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		end_of_test;
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h30, 32'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		$display("test reset done");
		wr(8'h0c, 32'hff);
		wr(8'h10, 32'hff);
		wr(8'h14, 32'hff);
		rd(8'h14, 32'h3f);
		wr(8'h18, 32'h6);
		rd(8'h14, 32'h20);
		rd(8'h0c, 32'h0);
		wr(8'h14, 32'h0);
		wr(8'h08, 32'h15a);
		rd(8'h08, 32'h5a);
		wr(8'h18, 32'h2);
		$display("test pointer done");
		wr(8'h04, 32'h55);
		wr(8'h04, 32'haa);
		wr(8'h00, 32'h1a);
		rd(8'h00, 32'h3a);
		wr(8'h00, 32'h0a);
		rd(8'h00, 32'h3a);
		wait_idle;
		rd(8'h00, 32'h0a);
		rd(8'h1c, 32'h1);
		wr(8'h24, 32'h1);
		rd(8'h1c, 32'h1);
		chk("irq", {31'h0, irq}, 32'h1);
		wr(8'h20, 32'h1);
		rd(8'h1c, 32'h0);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(8'h18, 32'h1);
		rd(8'h08, 32'h5a);
		$display("test write done");
		go(32'h12);
		rd(8'h00, 32'h02);
		go(32'h1e);
		wr(8'h18, 32'h1);
		rd(8'h08, 32'hff);
		wr(8'h14, 32'h20);
		wr(8'h08, 32'h33);
		go(32'h19);
		wr(8'h18, 32'h1);
		rd(8'h08, 32'h33);
		$display("test erase done");
		end_of_test;
	end
endmodule // ntac_nvm_ctrl_tb
